// *** core/sbsp_map.vh ***
// Constants for the synchronous burst static memory port.
// Assumes inclusion by core/sbsp_port.v and core/sbsp_fifo.v only.
`ifndef SBSP_MAP_VH
`define SBSP_MAP_VH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define SBSP_LANE_DATA_W   8
`define SBSP_LANE_W        9
`define SBSP_LANES         4
`define SBSP_ADDR_W        10
`define SBSP_BURST_W       2
`define SBSP_FIFO_DEPTH    16

// ----------------------------------------------------------------------------
// Operation codes carried down the pipeline
// ----------------------------------------------------------------------------
`define SBSP_OP_W          2
`define SBSP_OP_IDLE       2'h0
`define SBSP_OP_READ       2'h1
`define SBSP_OP_WRITE      2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SBSP_PIPE_DEPTH    2
`define SBSP_SLEEP_CYC     2
`define SBSP_SLEEP_CNT_W   2

`endif

// *** core/sbsp_fifo.v ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`include "sbsp_map.vh"

module sbsp_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = `SBSP_FIFO_DEPTH,
  parameter AW    = 4
) (
  input  wire             mclk_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_q[rd_ptr_q];

  always @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // sbsp_fifo

// *** core/sbsp_port.v ***
// Synchronous pipelined burst static memory: port logic and storage array.
// Assumes all inputs synchronous to mclk_i; the data bus wire is resolved outside.
`timescale 1ns/1ns
`include "sbsp_map.vh"

module sbsp_port #(
  parameter ADDR_W = `SBSP_ADDR_W,
  parameter LANES  = `SBSP_LANES
) (
  input  wire                        mclk_i,
  input  wire                        reset_n_i,
  input  wire                        chip_select_n_i,
  input  wire                        second_chip_select_i,
  input  wire                        second_chip_select_n_i,
  input  wire                        burst_continue_load_i,
  input  wire                        write_select_n_i,
  input  wire [LANES-1:0]            byte_lane_write_n_i,
  input  wire                        clock_gate_n_i,
  input  wire                        output_enable_n_i,
  input  wire                        sleep_request_i,
  input  wire                        burst_order_sel_i,
  input  wire [ADDR_W-1:0]           address_i,
  input  wire [LANES*8-1:0]          byte_lane_data_i,
  input  wire [LANES-1:0]            byte_lane_parity_i,
  output reg  [LANES*8-1:0]          byte_lane_data_o,
  output reg  [LANES-1:0]            byte_lane_parity_o,
  output wire                        byte_lane_data_oe_o,
  output wire                        sleeping_o
);

  localparam WORD_W = LANES * `SBSP_LANE_W;
  localparam DEPTH  = 1 << ADDR_W;

  // ----------------------------------------------------------------------------
  // Burst state and decode
  // ----------------------------------------------------------------------------
  localparam ST_DESEL = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg [1:0]                    state_q;
  reg [1:0]                    state_d;
  reg [ADDR_W-1:0]             base_q;
  reg [`SBSP_BURST_W-1:0]      beat_q;
  reg [`SBSP_BURST_W-1:0]      beat_d;
  reg [`SBSP_SLEEP_CNT_W-1:0]  sleep_cnt_q;
  reg                          asleep_q;
  reg [WORD_W-1:0]             mem_q [0:DEPTH-1];

  wire selected = ~chip_select_n_i & second_chip_select_i & ~second_chip_select_n_i;
  wire live     = ~clock_gate_n_i & ~asleep_q;
  wire cont     = burst_continue_load_i;
  wire all_off  = &byte_lane_write_n_i;

  // Start bits combined with the beat count, wrapping within four words.
  wire [`SBSP_BURST_W-1:0] start_bits = base_q[`SBSP_BURST_W-1:0];
  wire [`SBSP_BURST_W-1:0] low_bits   = burst_order_sel_i ? (start_bits ^ beat_d)
                                                          : (start_bits + beat_d);
  wire [ADDR_W-1:0] ext_addr  = address_i;
  wire [ADDR_W-1:0] burst_adr = {base_q[ADDR_W-1:`SBSP_BURST_W], low_bits};

  reg              op_valid;
  reg [`SBSP_OP_W-1:0] op_code;
  reg [ADDR_W-1:0] op_addr;

  always @* begin
    state_d  = state_q;
    beat_d   = beat_q;
    op_valid = 1'b0;
    op_code  = `SBSP_OP_IDLE;
    op_addr  = ext_addr;
    if (live) begin
      if (!cont) begin
        beat_d = {`SBSP_BURST_W{1'b0}};
        if (!selected) begin
          state_d = ST_DESEL;
        end else if (write_select_n_i) begin
          state_d  = ST_READ;
          op_valid = 1'b1;
          op_code  = `SBSP_OP_READ;
        end else begin
          state_d  = ST_WRITE;
          op_valid = 1'b1;
          op_code  = all_off ? `SBSP_OP_IDLE : `SBSP_OP_WRITE;
        end
      end else begin
        case (state_q)
          ST_DESEL: begin
            state_d = ST_DESEL;
          end
          ST_READ: begin
            beat_d   = beat_q + 1'b1;
            op_valid = 1'b1;
            op_code  = `SBSP_OP_READ;
            op_addr  = burst_adr;
          end
          ST_WRITE: begin
            beat_d   = beat_q + 1'b1;
            op_valid = 1'b1;
            op_code  = all_off ? `SBSP_OP_IDLE : `SBSP_OP_WRITE;
            op_addr  = burst_adr;
          end
          default: begin
            state_d = ST_DESEL;
          end
        endcase
      end
    end
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_DESEL;
      base_q  <= {ADDR_W{1'b0}};
      beat_q  <= {`SBSP_BURST_W{1'b0}};
    end else begin
      state_q <= state_d;
      beat_q  <= beat_d;
      if (live && !cont) begin
        base_q <= ext_addr;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Sleep entry and exit
  // ----------------------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_cnt_q <= {`SBSP_SLEEP_CNT_W{1'b0}};
      asleep_q    <= 1'b0;
    end else if (sleep_request_i != asleep_q) begin
      if (sleep_cnt_q == `SBSP_SLEEP_CYC - 1) begin
        asleep_q    <= sleep_request_i;
        sleep_cnt_q <= {`SBSP_SLEEP_CNT_W{1'b0}};
      end else begin
        sleep_cnt_q <= sleep_cnt_q + 1'b1;
      end
    end else begin
      sleep_cnt_q <= {`SBSP_SLEEP_CNT_W{1'b0}};
    end
  end

  assign sleeping_o = asleep_q;

  // ----------------------------------------------------------------------------
  // Two-stage pipeline: address cycle, then data cycle two edges later
  // ----------------------------------------------------------------------------
  reg [`SBSP_OP_W-1:0] p1_op_q;
  reg [ADDR_W-1:0]     p1_addr_q;
  reg [LANES-1:0]      p1_mask_q;
  reg [`SBSP_OP_W-1:0] p2_op_q;
  reg [ADDR_W-1:0]     p2_addr_q;
  reg [LANES-1:0]      p2_mask_q;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p1_op_q   <= `SBSP_OP_IDLE;
      p1_addr_q <= {ADDR_W{1'b0}};
      p1_mask_q <= {LANES{1'b1}};
      p2_op_q   <= `SBSP_OP_IDLE;
      p2_addr_q <= {ADDR_W{1'b0}};
      p2_mask_q <= {LANES{1'b1}};
    end else if (!clock_gate_n_i) begin
      p1_op_q   <= op_valid ? op_code : `SBSP_OP_IDLE;
      p1_addr_q <= op_addr;
      p1_mask_q <= byte_lane_write_n_i;
      p2_op_q   <= p1_op_q;
      p2_addr_q <= p1_addr_q;
      p2_mask_q <= p1_mask_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Write path through the FIFO, then into the array
  // ----------------------------------------------------------------------------
  wire              wr_push = ~clock_gate_n_i & (p2_op_q == `SBSP_OP_WRITE);
  wire              wr_in_ready;
  wire [WORD_W-1:0] wr_word;
  wire [WORD_W-1:0] wr_entry;
  wire              wr_valid;
  wire [WORD_W+ADDR_W+LANES-1:0] wr_in;
  wire [WORD_W+ADDR_W+LANES-1:0] wr_out;
  reg  [WORD_W-1:0] merged;
  integer           ln;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_pack
      assign wr_word[g*`SBSP_LANE_W +: `SBSP_LANE_W] =
        {byte_lane_parity_i[g], byte_lane_data_i[g*8 +: 8]};
    end
  endgenerate

  assign wr_in    = {p2_mask_q, p2_addr_q, wr_word};
  assign wr_entry = wr_out[WORD_W-1:0];

  sbsp_fifo #(
    .WIDTH (WORD_W + ADDR_W + LANES),
    .DEPTH (`SBSP_FIFO_DEPTH),
    .AW    (4)
  ) u_wr_fifo (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (wr_in),
    .in_valid_i  (wr_push),
    .in_ready_o  (wr_in_ready),
    .out_data_o  (wr_out),
    .out_valid_o (wr_valid),
    .out_ready_i (1'b1)
  );

  wire [ADDR_W-1:0] drain_addr = wr_out[WORD_W +: ADDR_W];
  wire [LANES-1:0]  drain_mask = wr_out[WORD_W+ADDR_W +: LANES];

  always @* begin
    merged = mem_q[drain_addr];
    for (ln = 0; ln < LANES; ln = ln + 1) begin
      if (!drain_mask[ln]) begin
        merged[ln*`SBSP_LANE_W +: `SBSP_LANE_W] =
          wr_entry[ln*`SBSP_LANE_W +: `SBSP_LANE_W];
      end
    end
  end

  always @(posedge mclk_i) begin
    if (wr_valid) begin
      mem_q[drain_addr] <= merged;
    end
  end

  // ----------------------------------------------------------------------------
  // Read path: data register and bus drive
  // ----------------------------------------------------------------------------
  // The FIFO drains every cycle, so one pending write to the same word is
  // forwarded to keep read-after-write coherent.
  wire [WORD_W-1:0] rd_raw = (wr_valid && drain_addr == p1_addr_q) ? merged
                                                                   : mem_q[p1_addr_q];
  reg              rd_drive_q;
  reg [WORD_W-1:0] rd_word;
  integer          k;
  integer          q;

  // A write whose data is being captured at this very edge has not reached the
  // FIFO yet, so a read of the same word one cycle behind it takes it from here.
  always @* begin
    rd_word = rd_raw;
    if (p2_op_q == `SBSP_OP_WRITE && p2_addr_q == p1_addr_q) begin
      for (q = 0; q < LANES; q = q + 1) begin
        if (!p2_mask_q[q]) begin
          rd_word[q*`SBSP_LANE_W +: `SBSP_LANE_W] =
            wr_word[q*`SBSP_LANE_W +: `SBSP_LANE_W];
        end
      end
    end
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      byte_lane_data_o   <= {LANES*8{1'b0}};
      byte_lane_parity_o <= {LANES{1'b0}};
      rd_drive_q         <= 1'b0;
    end else if (!clock_gate_n_i) begin
      rd_drive_q <= (p1_op_q == `SBSP_OP_READ);
      for (k = 0; k < LANES; k = k + 1) begin
        byte_lane_data_o[k*8 +: 8] <= rd_word[k*`SBSP_LANE_W +: 8];
        byte_lane_parity_o[k]      <= rd_word[k*`SBSP_LANE_W + 8];
      end
    end
  end

  assign byte_lane_data_oe_o = rd_drive_q & ~output_enable_n_i
                               & ~sleep_request_i & ~asleep_q;

endmodule // sbsp_port

// *** dv/sbsp_port_assertions.sv ***
// Checker for the burst memory port: bus drive, clock gating and sleep.
// Assumes one clock; bound to every sbsp_port instance.
`timescale 1ns/1ns
module sbsp_port_assertions #(
  parameter LANES = 4
) (
  input wire               mclk_i,
  input wire               reset_n_i,
  input wire               chip_select_n_i,
  input wire               second_chip_select_i,
  input wire               second_chip_select_n_i,
  input wire               burst_continue_load_i,
  input wire               write_select_n_i,
  input wire               clock_gate_n_i,
  input wire               output_enable_n_i,
  input wire               sleep_request_i,
  input wire [LANES*8-1:0] byte_lane_data_o,
  input wire [LANES-1:0]   byte_lane_parity_o,
  input wire               byte_lane_data_oe_o,
  input wire               sleeping_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------------------------------------
  // Edges the port acts on
  // ----------------------------------------------------------------------
  wire go  = !clock_gate_n_i && !sleep_request_i && !sleeping_o;
  wire sel = !chip_select_n_i && second_chip_select_i && !second_chip_select_n_i;
  wire ld  = go && !burst_continue_load_i;

  a_sleep_quiet: assert property (sleep_request_i |-> !byte_lane_data_oe_o)
    else $error("bus driven in sleep");
  a_oe_off_quiet: assert property (output_enable_n_i |-> !byte_lane_data_oe_o)
    else $error("bus driven with output enable off");
  a_read_drives: assert property (ld && sel && write_select_n_i ##1 !clock_gate_n_i
    ##1 (!output_enable_n_i && !sleep_request_i && !sleeping_o) |-> byte_lane_data_oe_o)
    else $error("read data not driven two edges on");
  a_write_quiet: assert property (ld && sel && !write_select_n_i ##1 !clock_gate_n_i
    |=> !byte_lane_data_oe_o)
    else $error("bus driven for a write");
  a_desel_quiet: assert property (ld && !sel ##1 !clock_gate_n_i |=> !byte_lane_data_oe_o)
    else $error("bus driven while deselected");
  a_cont_desel: assert property (ld && !sel ##1 (go && burst_continue_load_i)
    ##1 !clock_gate_n_i |=> !byte_lane_data_oe_o)
    else $error("continue after deselect drove the bus");
  a_gate_hold: assert property (clock_gate_n_i
    |=> $stable(byte_lane_data_o) && $stable(byte_lane_parity_o))
    else $error("read data moved on a gated edge");
  a_sleep_enter: assert property ($rose(sleep_request_i) ##1 sleep_request_i [*4]
    |-> sleeping_o)
    else $error("sleep not entered in time");
endmodule // sbsp_port_assertions

bind sbsp_port sbsp_port_assertions #(.LANES(LANES)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .chip_select_n_i(chip_select_n_i),
  .second_chip_select_i(second_chip_select_i),
  .second_chip_select_n_i(second_chip_select_n_i),
  .burst_continue_load_i(burst_continue_load_i), .write_select_n_i(write_select_n_i),
  .clock_gate_n_i(clock_gate_n_i), .output_enable_n_i(output_enable_n_i),
  .sleep_request_i(sleep_request_i), .byte_lane_data_o(byte_lane_data_o),
  .byte_lane_parity_o(byte_lane_parity_o), .byte_lane_data_oe_o(byte_lane_data_oe_o),
  .sleeping_o(sleeping_o));

// *** dv/sbsp_ctrl_model.sv ***
// Controller model that drives the burst memory port from the far side.
// Assumes a 100 MHz mclk_i; the bench calls beat at most once per cycle.
`timescale 1ns/1ns
module sbsp_ctrl_model (
  input  wire        mclk_i,
  input  wire [31:0] rd_data_i,
  input  wire [3:0]  rd_par_i,
  input  wire        rd_oe_i,
  output reg         cs_n_o,
  output reg         sel2_o,
  output reg         sel2_n_o,
  output reg         cont_o,
  output reg         we_n_o,
  output reg  [3:0]  bw_n_o,
  output reg         gate_n_o,
  output reg         oe_n_o,
  output reg         sleep_o,
  output wire        order_o,
  output reg  [9:0]  addr_o,
  output reg  [35:0] wd_o
);
  reg   [37:0] pipe_q [0:3];
  reg          rd_oe_n = 1'b0;
  reg          watch   = 1'b1;
  reg          moved;
  logic [36:0] got [$];

  assign order_o = 1'b1;
  initial begin
    {cs_n_o, sel2_o, sel2_n_o, cont_o, we_n_o, gate_n_o, oe_n_o, sleep_o} = 8'hCA;
    bw_n_o = 4'hF;
    addr_o = 10'h000;
    wd_o   = 36'h000000000;
    for (int i = 0; i < 4; i++) pipe_q[i] = 38'h0;
  end

  // ----------------------------------------------------------------------
  // One command a cycle; write data follows two edges later.
  // ----------------------------------------------------------------------
  task beat(input logic cont, input logic wr, input logic [1:0] dsel,
            input logic [3:0] bw, input logic [9:0] a, input logic [35:0] d);
    @(posedge mclk_i);
    #1;
    gate_n_o  = 1'b0;
    cont_o    = cont;
    we_n_o    = !wr;
    cs_n_o    = dsel == 2'h1;
    sel2_o    = dsel != 2'h2;
    sel2_n_o  = dsel == 2'h3;
    bw_n_o    = bw;
    addr_o    = a;
    oe_n_o    = wr | rd_oe_n;
    pipe_q[0] = {wr, !wr && watch, d};
  endtask

  // The bus is not left holding old data across an ungated edge, so a late sample shows up.
  always @(posedge mclk_i) begin
    moved = !gate_n_o;
    // Read data stands from the previous ungated edge up to this one.
    if (moved && pipe_q[2][36]) got.push_back({rd_oe_i, rd_par_i, rd_data_i});
    if (moved) begin
      for (int j = 3; j > 0; j--) pipe_q[j] = pipe_q[j-1];
      pipe_q[0] = 38'h0;
    end
    #2;
    if (moved) wd_o = pipe_q[2][37] ? pipe_q[2][35:0] : ~wd_o;
  end
endmodule // sbsp_ctrl_model

// *** dv/sbsp_port_tb.sv ***
// Self-checking bench for the burst memory port.
// Assumes the controller model drives every port input except mclk_i and reset_n_i.
`timescale 1ns/1ns
module sbsp_port_tb;
  localparam logic [9:0] A = 10'h0E6;
  logic        mclk_i     = 1'b0;
  logic        reset_n_i  = 1'b0;
  wire         cs_n, sel2, sel2_n, cont, we_n, gate_n, oe_n, slp, ord, roe, sleeping;
  wire  [3:0]  bw_n, rpar;
  wire  [9:0]  addr;
  wire  [31:0] rdat;
  wire  [35:0] wd;
  logic [35:0] want [0:3];
  integer      fail_count = 0;
  integer      tests_run  = 0;

  initial forever #5 mclk_i = ~mclk_i;

  sbsp_ctrl_model ctrl (.mclk_i(mclk_i), .rd_data_i(rdat), .rd_par_i(rpar), .rd_oe_i(roe),
    .cs_n_o(cs_n), .sel2_o(sel2), .sel2_n_o(sel2_n), .cont_o(cont), .we_n_o(we_n),
    .bw_n_o(bw_n),
    .gate_n_o(gate_n), .oe_n_o(oe_n), .sleep_o(slp), .order_o(ord), .addr_o(addr),
    .wd_o(wd));
  sbsp_port dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
    .second_chip_select_i(sel2), .second_chip_select_n_i(sel2_n),
    .burst_continue_load_i(cont), .write_select_n_i(we_n), .byte_lane_write_n_i(bw_n),
    .clock_gate_n_i(gate_n), .output_enable_n_i(oe_n), .sleep_request_i(slp),
    .burst_order_sel_i(ord), .address_i(addr), .byte_lane_data_i(wd[31:0]),
    .byte_lane_parity_i(wd[35:32]), .byte_lane_data_o(rdat), .byte_lane_parity_o(rpar),
    .byte_lane_data_oe_o(roe), .sleeping_o(sleeping));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [35:0] pat(input logic [3:0] j);
    pat = {j, j, 4'hC, j, 4'h3, j, 4'hA, j, 4'h5};
  endfunction

  function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
                                      input logic [3:0] m);
    mrg = o;
    for (int g = 0; g < 4; g++) if (!m[g]) begin
      mrg[8*g +: 8] = n[8*g +: 8];
      mrg[32+g]     = n[32+g];
    end
  endfunction

  task chk(input string what, input logic [36:0] e, input logic [36:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task take(output logic [36:0] v);
    v = ctrl.got.size() > 0 ? ctrl.got.pop_front() : 'x;
  endtask

  task idle(input integer n);
    ctrl.watch = 1'b0;
    repeat (n) ctrl.beat(1'b0, 1'b0, 2'h1, 4'hF, A, 36'h0);
    ctrl.watch = 1'b1;
  endtask

  task rd_chk(input logic gap);
    logic [36:0] v;
    ctrl.got.delete();
    ctrl.beat(1'b0, 1'b0, 2'h0, 4'hF, A, 36'h0);
    if (gap) begin
      @(posedge mclk_i);
      #1;
      ctrl.gate_n_o = 1'b1;
      ctrl.cont_o   = 1'b0;
      ctrl.addr_o   = ~A;
    end
    for (int j = 1; j < 4; j++) ctrl.beat(1'b1, 1'b0, 2'h2, 4'h0, ~A, 36'h0);
    idle(4);
    for (int j = 0; j < 4; j++) begin
      take(v);
      chk("read beat", {1'b1, want[j]}, v);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_burst;
    logic [3:0] m [0:3];
    m = '{4'hF, 4'hF, 4'hE, 4'h5};
    for (int j = 0; j < 4; j++) ctrl.beat(j != 0, 1'b1, 2'h0, 4'h0, A, pat(4'(j)));
    for (int j = 0; j < 4; j++) begin
      ctrl.beat(j != 0, 1'b1, {1'b0, j != 0}, m[j], j != 0 ? 10'h3FF : A, pat(4'(j + 4)));
      want[j] = mrg(pat(4'(j)), pat(4'(j + 4)), m[j]);
    end
    rd_chk(1'b0);
    $display("burst test done");
  endtask

  task t_dummy;
    logic [36:0] v;
    ctrl.got.delete();
    ctrl.rd_oe_n = 1'b1;
    ctrl.beat(1'b0, 1'b0, 2'h0, 4'hF, A, 36'h0);
    ctrl.beat(1'b1, 1'b0, 2'h0, 4'hF, A, 36'h0);
    idle(4);
    ctrl.rd_oe_n = 1'b0;
    repeat (2) begin
      take(v);
      chk("dummy drive", 37'h0, {v[36], 36'h0});
    end
    $display("dummy read test done");
  endtask

  task t_desel;
    logic [36:0] v;
    ctrl.got.delete();
    for (int s = 1; s < 4; s++) begin
      ctrl.beat(1'b0, 1'b0, 2'(s), 4'hF, A, 36'h0);
      ctrl.beat(1'b1, 1'b0, 2'h0, 4'hF, A, 36'h0);
    end
    idle(4);
    repeat (6) begin
      take(v);
      chk("deselect drive", 37'h0, {v[36], 36'h0});
    end
    $display("deselect test done");
  endtask

  task t_sleep;
    @(posedge mclk_i);
    #1;
    ctrl.sleep_o = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    chk("sleeping flag", 37'h1, {36'h0, sleeping});
    ctrl.beat(1'b0, 1'b1, 2'h0, 4'h0, A, pat(4'hF));
    idle(1);
    ctrl.sleep_o = 1'b0;
    idle(4);
    rd_chk(1'b0);
    $display("sleep test done");
  endtask

  initial begin
    repeat (10) @(posedge mclk_i);
    #1;
    reset_n_i = 1'b1;
    t_burst;
    t_dummy;
    t_desel;
    rd_chk(1'b1);
    $display("gate test done");
    t_sleep;
    conclude;
  end

  initial begin
    #20000;
    fail_count = fail_count + 1;
    conclude;
  end
endmodule // sbsp_port_tb
